//--- rtl/relay_io_matrix.sv
// Relay output routing matrix with conditioned digital inputs and registers
// Notes on behaviour
// - Any source routes to any output
// - Crosspoint: open, connected, or connected and latched
// - Output bit one means coil energized
// - Contact type decided outside; coil de-energized is normal
// - Each output selectable latched or not
// - Output status writes act only with force on
// - Logic binding sets its crosspoint automatically
// - Conditioned inputs are matrix sources too
// - Per input polarity and delay
// - Delay equal for activation and deactivation
// - Per input on, off, alarm enables, counter
// - One state bit per input
// - Active edge rising for NO, falling NC
// - Counter increments on active edge, 16 bits
//
// The implementer's own choices: the register addresses and strobed register access.
`timescale 1ns/1ps
module relay_io_matrix #(
	parameter int NUM_SIG = 8,
	parameter int NUM_DI = 8,
	parameter int NUM_TRIP = 6,
	parameter int TICK_DIV = relay_io_pkg::TICK_CYCLES
) (
	input wire logic clk,
	input wire logic resetn,
	input wire relay_io_pkg::reg_req_s req,
	output logic [relay_io_pkg::DATA_W-1:0] rdata,
	output logic irq,
	input wire logic [NUM_SIG-1:0] internalSig,
	input wire relay_io_pkg::logic_bind_s logicBind,
	input wire logic [NUM_DI-1:0] digitalInputN,
	output logic [NUM_DI-1:0] diState,
	output logic [NUM_TRIP-1:0] tripOutputN,
	output logic alarmSignalOutput,
	output logic serviceStatusOutput
);
	import relay_io_pkg::*;

	// Sizes; sources are internal signals first, then the inputs
	localparam int NUM_OUT = NUM_TRIP + 2;
	localparam int NUM_SRC = NUM_SIG + NUM_DI;
	localparam int IRQ_W = 3 * NUM_DI;

	// Whole block state
	typedef struct packed {
		logic forceOn; // Test forcing of outputs enabled
		logic [NUM_OUT-1:0] outForce; // Forced coil values
		logic [NUM_OUT-1:0] outLatchCfg; // Output is latched type
		logic [NUM_OUT-1:0] outHold; // Output latch memory
		logic [NUM_OUT-1:0] coil; // Coil drive, one is energized
		logic [NUM_OUT-1:0][NUM_SRC-1:0] conn; // Crosspoint connected
		logic [NUM_OUT-1:0][NUM_SRC-1:0] xpLatch; // Crosspoint latched
		logic [NUM_OUT-1:0][NUM_SRC-1:0] xpHold; // Crosspoint latch memory
		logic [NUM_DI-1:0] diPol; // One selects normally closed
		logic [NUM_DI-1:0] diAc; // One selects ac mode
		logic [NUM_DI-1:0] onEn; // On event enable
		logic [NUM_DI-1:0] offEn; // Off event enable
		logic [NUM_DI-1:0] almEn; // Alarm pop-up enable
		logic [NUM_DI-1:0][DELAY_W-1:0] delay; // Delay in 10 ms steps
		logic [NUM_DI-1:0][CNT_W-1:0] count; // Operation counters
		logic [IRQ_W-1:0] irqSt; // Sticky event status
		logic [IRQ_W-1:0] irqEn; // Event enables onto irq
		logic irq; // Interrupt level
		logic tick; // 10 ms step pulse
		logic [TICK_W-1:0] tickCnt; // Step divider
		logic [DATA_W-1:0] rdata; // Read answer
	} state_s;

	state_s s_q;
	state_s s_d;

	// Conditioner outputs
	logic [NUM_DI-1:0] diLevel;
	logic [NUM_DI-1:0] diRise;
	logic [NUM_DI-1:0] diFall;

	// Combinational helpers
	logic [NUM_SRC-1:0] src;
	logic [NUM_DI-1:0] actEdge;
	logic [NUM_DI-1:0] inactEdge;
	logic [IRQ_W-1:0] irqEvent;
	logic [IRQ_W-1:0] irqClear;
	logic releaseCmd;
	logic routed;

	// One conditioner per input
	for (genvar g = 0; g < NUM_DI; g++) begin : gen_di
		di_conditioner u_cond (
			.clk(clk),
			.resetn(resetn),
			.tick(s_q.tick),
			.rawIn(digitalInputN[g]),
			.acMode(s_q.diAc[g]),
			.delaySteps(s_q.delay[g]),
			.stateOut(diLevel[g]),
			.rise(diRise[g]),
			.fall(diFall[g])
		);
	end

	// Next state of the whole block
	always_comb begin
		s_d = s_q;
		releaseCmd = 1'b0;
		irqClear = '0;
		routed = 1'b0;

		// Step divider; the count is a parameter so simulation can shorten it
		if (s_q.tickCnt == TICK_W'(TICK_DIV - 1)) begin
			s_d.tickCnt = '0;
			s_d.tick = 1'b1;
		end else begin
			s_d.tickCnt = s_q.tickCnt + 1'b1;
			s_d.tick = 1'b0;
		end

		// Register writes
		if (req.wr) begin
			// Fixed registers
			if (req.addr == ADDR_CTRL) begin
				s_d.forceOn = req.wdata[CTRL_FORCE_BIT];
				releaseCmd = req.wdata[CTRL_RELEASE_BIT];
			end
			// Force values are refused unless the force flag is already on
			if (req.addr == ADDR_OUT_FORCE && s_q.forceOn) begin
				s_d.outForce = req.wdata[NUM_OUT-1:0];
			end
			if (req.addr == ADDR_OUT_LATCH) begin
				s_d.outLatchCfg = req.wdata[NUM_OUT-1:0];
			end
			if (req.addr == ADDR_DI_POL) begin
				s_d.diPol = req.wdata[NUM_DI-1:0];
			end
			if (req.addr == ADDR_DI_AC) begin
				s_d.diAc = req.wdata[NUM_DI-1:0];
			end
			if (req.addr == ADDR_DI_ON_EN) begin
				s_d.onEn = req.wdata[NUM_DI-1:0];
			end
			if (req.addr == ADDR_DI_OFF_EN) begin
				s_d.offEn = req.wdata[NUM_DI-1:0];
			end
			if (req.addr == ADDR_DI_ALM_EN) begin
				s_d.almEn = req.wdata[NUM_DI-1:0];
			end
			if (req.addr == ADDR_IRQ_CLEAR) begin
				irqClear = req.wdata[IRQ_W-1:0];
			end
			if (req.addr == ADDR_IRQ_ENABLE) begin
				s_d.irqEn = req.wdata[IRQ_W-1:0];
			end
			// Per input delay and counter preset
			for (int i = 0; i < NUM_DI; i++) begin
				if (req.addr == ADDR_DI_DELAY_BASE + ADDR_W'(4 * i)) begin
					// Values beyond 60 s are clamped if they fit the 13-bit field; write bits above it are dropped
					if (req.wdata[DELAY_W-1:0] > DELAY_MAX) begin
						s_d.delay[i] = DELAY_MAX;
					end else begin
						s_d.delay[i] = req.wdata[DELAY_W-1:0];
					end
				end
				if (req.addr == ADDR_DI_COUNT_BASE + ADDR_W'(4 * i)) begin
					s_d.count[i] = req.wdata[CNT_W-1:0];
				end
			end
			// Crosspoint rows, one word per output
			for (int o = 0; o < NUM_OUT; o++) begin
				if (req.addr == ADDR_XP_BASE + ADDR_W'(4 * o)) begin
					s_d.conn[o] = req.wdata[NUM_SRC-1:0];
					s_d.xpLatch[o] = req.wdata[XP_LATCH_LSB +: NUM_SRC];
				end
			end
		end

		// Building logic onto an output connects its crosspoint
		if (logicBind.valid && 32'(logicBind.out) < NUM_OUT
				&& 32'(logicBind.src) < NUM_SRC) begin
			s_d.conn[logicBind.out][logicBind.src] = 1'b1;
		end

		// Active edge depends on polarity
		for (int i = 0; i < NUM_DI; i++) begin
			actEdge[i] = s_q.diPol[i] ? diFall[i] : diRise[i];
			inactEdge[i] = s_q.diPol[i] ? diRise[i] : diFall[i];
			// Counter wraps past 65535; an edge during a preset still counts
			if (actEdge[i]) begin
				s_d.count[i] = s_d.count[i] + 1'b1;
			end
		end

		// Sources: internal signals, then conditioned inputs
		src = {diLevel, internalSig};

		// Routing through the matrix
		for (int o = 0; o < NUM_OUT; o++) begin
			// Latched crosspoints remember; a new set beats the release
			s_d.xpHold[o] = (s_q.xpHold[o] & {NUM_SRC{~releaseCmd}})
				| (src & s_q.conn[o] & s_q.xpLatch[o]);
			routed = |(src & s_q.conn[o]) | (|s_q.xpHold[o]);
			// Latched output type keeps the coil on until release
			if (s_q.outLatchCfg[o]) begin
				s_d.outHold[o] = (s_q.outHold[o] & ~releaseCmd) | routed;
			end else begin
				s_d.outHold[o] = 1'b0;
			end
			// Coil bit one energizes; forcing overrides the matrix
			if (s_q.forceOn) begin
				s_d.coil[o] = s_q.outForce[o];
			end else begin
				s_d.coil[o] = routed | s_q.outHold[o];
			end
		end

		// Events; set beats a clear in the same cycle
		irqEvent = {s_q.almEn & actEdge, s_q.offEn & inactEdge, s_q.onEn & actEdge};
		s_d.irqSt = (s_q.irqSt & ~irqClear) | irqEvent;
		s_d.irq = |(s_d.irqSt & s_d.irqEn);

		// Read answer in the cycle after the strobe; unmapped reads are zero
		s_d.rdata = '0;
		if (req.rd) begin
			unique case (req.addr)
				ADDR_CTRL: s_d.rdata[CTRL_FORCE_BIT] = s_q.forceOn;
				ADDR_OUT_FORCE: s_d.rdata = DATA_W'(s_q.outForce);
				ADDR_OUT_STATE: s_d.rdata = DATA_W'(s_q.coil);
				ADDR_OUT_LATCH: s_d.rdata = DATA_W'(s_q.outLatchCfg);
				ADDR_DI_POL: s_d.rdata = DATA_W'(s_q.diPol);
				ADDR_DI_AC: s_d.rdata = DATA_W'(s_q.diAc);
				ADDR_DI_STATE: s_d.rdata = DATA_W'(diLevel);
				ADDR_DI_ON_EN: s_d.rdata = DATA_W'(s_q.onEn);
				ADDR_DI_OFF_EN: s_d.rdata = DATA_W'(s_q.offEn);
				ADDR_DI_ALM_EN: s_d.rdata = DATA_W'(s_q.almEn);
				ADDR_IRQ_STATUS: s_d.rdata = DATA_W'(s_q.irqSt);
				ADDR_IRQ_ENABLE: s_d.rdata = DATA_W'(s_q.irqEn);
				default: begin
					// Indexed registers; anything else stays zero
					for (int i = 0; i < NUM_DI; i++) begin
						if (req.addr == ADDR_DI_DELAY_BASE + ADDR_W'(4 * i)) begin
							s_d.rdata = DATA_W'(s_q.delay[i]);
						end
						if (req.addr == ADDR_DI_COUNT_BASE + ADDR_W'(4 * i)) begin
							s_d.rdata = DATA_W'(s_q.count[i]);
						end
					end
					for (int o = 0; o < NUM_OUT; o++) begin
						if (req.addr == ADDR_XP_BASE + ADDR_W'(4 * o)) begin
							s_d.rdata[NUM_SRC-1:0] = s_q.conn[o];
							s_d.rdata[XP_LATCH_LSB +: NUM_SRC] = s_q.xpLatch[o];
						end
					end
				end
			endcase
		end
	end

	// State register; all fields clear, force flag at its reset value
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			s_q <= '0;
			s_q.forceOn <= FORCE_RST;
		end else begin
			s_q <= s_d;
		end
	end

	// Outputs straight from flip-flops; contact type is the wiring's concern
	assign tripOutputN = s_q.coil[NUM_TRIP-1:0];
	assign alarmSignalOutput = s_q.coil[NUM_TRIP];
	assign serviceStatusOutput = s_q.coil[NUM_TRIP+1];
	assign diState = diLevel;
	assign rdata = s_q.rdata;
	assign irq = s_q.irq;
endmodule

//--- rtl/relay_io_pkg.sv
// Shared constants and carrier types for the relay input and output matrix block
package relay_io_pkg;

	// Register bus widths
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;

	// Register bus request, one cycle per strobe
	typedef struct packed {
		logic [ADDR_W-1:0] addr; // Byte address, word aligned
		logic [DATA_W-1:0] wdata; // Write data
		logic wr; // Write strobe
		logic rd; // Read strobe
	} reg_req_s;

	// Logic engine request to bind a source to an output crosspoint
	typedef struct packed {
		logic valid; // One-cycle pulse
		logic [3:0] src; // Matrix source index
		logic [3:0] out; // Output index
	} logic_bind_s;

	// Register offsets (byte addresses)
	localparam logic [ADDR_W-1:0] ADDR_CTRL = 12'h000;
	localparam logic [ADDR_W-1:0] ADDR_OUT_FORCE = 12'h004;
	localparam logic [ADDR_W-1:0] ADDR_OUT_STATE = 12'h008;
	localparam logic [ADDR_W-1:0] ADDR_OUT_LATCH = 12'h00c;
	localparam logic [ADDR_W-1:0] ADDR_DI_POL = 12'h010;
	localparam logic [ADDR_W-1:0] ADDR_DI_AC = 12'h014;
	localparam logic [ADDR_W-1:0] ADDR_DI_STATE = 12'h018;
	localparam logic [ADDR_W-1:0] ADDR_DI_ON_EN = 12'h01c;
	localparam logic [ADDR_W-1:0] ADDR_DI_OFF_EN = 12'h020;
	localparam logic [ADDR_W-1:0] ADDR_DI_ALM_EN = 12'h024;
	localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS = 12'h028;
	localparam logic [ADDR_W-1:0] ADDR_IRQ_CLEAR = 12'h02c;
	localparam logic [ADDR_W-1:0] ADDR_IRQ_ENABLE = 12'h030;
	localparam logic [ADDR_W-1:0] ADDR_DI_DELAY_BASE = 12'h040;
	localparam logic [ADDR_W-1:0] ADDR_DI_COUNT_BASE = 12'h080;
	localparam logic [ADDR_W-1:0] ADDR_XP_BASE = 12'h100;

	// Field positions
	localparam int CTRL_FORCE_BIT = 0;
	localparam int CTRL_RELEASE_BIT = 1;
	localparam int XP_LATCH_LSB = 16;

	// Input delay: 0.00 to 60.00 s in 10 ms steps
	localparam int DELAY_W = 13;
	localparam logic [DELAY_W-1:0] DELAY_MAX = 13'h1770;
	localparam int DELAY_STEP_MS = 10;
	localparam int CLK_MHZ = 200;
	localparam int TICK_CYCLES = DELAY_STEP_MS * CLK_MHZ * 1000;
	localparam int TICK_W = 22;

	// Operation counter width, range 0 to 65535
	localparam int CNT_W = 16;

	// Ac mode bridges the gaps of a rectified ac input for this many delay steps
	localparam int AC_W = 2;
	localparam logic [AC_W-1:0] AC_HOLD_TICKS = 2'h2;

	// Force flag after reset
	localparam logic FORCE_RST = 1'b0;

endpackage

//--- rtl/di_conditioner.sv
// One digital input channel: ac bridging and symmetric on/off delay
`timescale 1ns/1ps
module di_conditioner
	import relay_io_pkg::*;
(
	input wire logic clk,
	input wire logic resetn,
	input wire logic tick,
	input wire logic rawIn,
	input wire logic acMode,
	input wire logic [DELAY_W-1:0] delaySteps,
	output logic stateOut,
	output logic rise,
	output logic fall
);
	import relay_io_pkg::*;

	// Channel state
	typedef struct packed {
		logic level; // Debounced input state
		logic rise; // Pulse on 0 to 1 of the state
		logic fall; // Pulse on 1 to 0 of the state
		logic [AC_W-1:0] acHold; // Remaining bridge steps in ac mode
		logic [DELAY_W-1:0] cnt; // Steps the mismatch has persisted
	} chan_s;

	chan_s s_q;
	chan_s s_d;
	logic seen;

	// Next state
	always_comb begin
		s_d = s_q;
		s_d.rise = 1'b0;
		s_d.fall = 1'b0;
		// Ac input drops out near zero crossings; hold the high for a few steps
		if (rawIn) begin
			s_d.acHold = AC_HOLD_TICKS;
		end else if (tick && s_q.acHold != '0) begin
			s_d.acHold = s_q.acHold - 1'b1;
		end
		seen = rawIn | (acMode & (s_q.acHold != '0));
		// A change must persist for the full delay, both directions alike
		if (seen == s_q.level) begin
			s_d.cnt = '0;
		end else if (s_q.cnt >= delaySteps) begin
			s_d.level = seen;
			s_d.rise = seen;
			s_d.fall = ~seen;
			s_d.cnt = '0;
		end else if (tick) begin
			s_d.cnt = s_q.cnt + 1'b1;
		end
	end

	// State register
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign stateOut = s_q.level;
	assign rise = s_q.rise;
	assign fall = s_q.fall;
endmodule

//--- verification/relay_io_checker.sv
// Port assertions for the relay input and output matrix
`timescale 1ns/1ps
module relay_io_checker #(
	parameter int NUM_SIG = 8,
	parameter int NUM_DI = 8,
	parameter int NUM_TRIP = 6
) (
	input wire logic clk,
	input wire logic resetn,
	input wire relay_io_pkg::reg_req_s req,
	input wire logic [relay_io_pkg::DATA_W-1:0] rdata,
	input wire logic irq,
	input wire logic [NUM_SIG-1:0] internalSig,
	input wire relay_io_pkg::logic_bind_s logicBind,
	input wire logic [NUM_DI-1:0] digitalInputN,
	input wire logic [NUM_DI-1:0] diState,
	input wire logic [NUM_TRIP-1:0] tripOutputN,
	input wire logic alarmSignalOutput,
	input wire logic serviceStatusOutput
);
	import relay_io_pkg::*;
	logic [NUM_TRIP+1:0] coils; // All coil bits
	logic [NUM_SIG+NUM_DI-1:0] srcPrev; // Sources one cycle back
	logic [NUM_DI-1:0] diPrev; // Input states one cycle back
	logic [NUM_DI-1:0] raw1, raw2, raw3; // Raw inputs up to three cycles back
	logic [2:0] causeQ; // Recent coil causes
	logic [3:0] evtQ; // Recent interrupt causes
	logic [2:0] wrQ; // Recent writes
	logic rdDi, rdOut, diChg, cause;
	// History only, so no reset: it is compared after release alone
	always_ff @(posedge clk) begin
		srcPrev <= {internalSig, diState};
		diPrev <= diState;
		raw1 <= digitalInputN;
		raw2 <= raw1;
		raw3 <= raw2;
		causeQ <= {causeQ[1:0], cause};
		evtQ <= {evtQ[2:0], diChg || req.wr};
		wrQ <= {wrQ[1:0], req.wr};
	end
	assign coils = {serviceStatusOutput, alarmSignalOutput, tripOutputN};
	assign rdDi = req.rd && req.addr == ADDR_DI_STATE;
	assign rdOut = req.rd && req.addr == ADDR_OUT_STATE;
	assign diChg = diState != diPrev;
	// A write may move a coil through force, latch release or crosspoints
	assign cause = ({internalSig, diState} != srcPrev) || req.wr || logicBind.valid;
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	rdata_idle_a: assert property (!$past(req.rd) |-> rdata == '0)
		else $error("read data outside a read answer");
	state_read_a: assert property ($past(rdDi) |-> rdata[NUM_DI-1:0] == $past(diState))
		else $error("input state read differs");
	coil_read_a: assert property ($past(rdOut) |-> rdata[NUM_TRIP+1:0] == $past(coils))
		else $error("coil state read differs");
	di_rise_a: assert property ((diState & ~diPrev & ~(raw1 | raw2 | raw3)) == '0)
		else $error("input state rose without raw input");
	di_fall_a: assert property ((~diState & diPrev & raw1 & raw2 & raw3) == '0)
		else $error("input state fell with raw input high");
	coil_cause_a: assert property (!$stable(coils) |-> causeQ != 3'h0)
		else $error("coil moved without a cause");
	irq_rise_a: assert property ($rose(irq) |-> evtQ != 4'h0)
		else $error("interrupt rose without an event");
	irq_fall_a: assert property ($fell(irq) |-> wrQ != 3'h0)
		else $error("interrupt fell without a write");
	cover property (logicBind.valid);
	cover property ($rose(irq));
	cover property ($past(rdDi) && rdata != '0);
endmodule
bind relay_io_matrix relay_io_checker #(.NUM_SIG(NUM_SIG), .NUM_DI(NUM_DI), .NUM_TRIP(NUM_TRIP))
	chk (.clk(clk), .resetn(resetn), .req(req), .rdata(rdata), .irq(irq),
	.internalSig(internalSig), .logicBind(logicBind), .digitalInputN(digitalInputN),
	.diState(diState), .tripOutputN(tripOutputN), .alarmSignalOutput(alarmSignalOutput),
	.serviceStatusOutput(serviceStatusOutput));

//--- verification/field_contacts.sv
// Field contact model that drives the raw digital inputs
`timescale 1ns/1ps
module field_contacts #(
	parameter int NUM_DI = 8
) (
	input wire logic clk,
	input wire logic [NUM_DI-1:0] activeReq,
	input wire logic [NUM_DI-1:0] ncType,
	input wire logic [NUM_DI-1:0] acFed,
	output logic [NUM_DI-1:0] digitalInputN
);
	logic [1:0] phase = 2'h0; // Mains phase, one gap cycle in four
	// Closed contacts carry voltage; ac-fed ones drop out once a period
	always_ff @(posedge clk) begin
		phase <= phase + 2'h1;
		digitalInputN <= (activeReq ^ ncType) & ~(acFed & {NUM_DI{phase == 2'h3}});
	end
endmodule

//--- verification/relay_io_matrix_bench.sv
// Self-checking bench for the relay input and output matrix
`timescale 1ns/1ps
module relay_io_matrix_bench;
	import relay_io_pkg::*;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	reg_req_s req = '0;
	logic [DATA_W-1:0] rdata;
	logic irq;
	logic [7:0] internalSig = '0;
	logic_bind_s logicBind = '0;
	logic [7:0] activeReq = '0; // Field contact activity
	logic [7:0] ncType = '0; // Field contact type
	logic [7:0] acFed = '0; // Contacts fed from ac
	logic [7:0] digitalInputN, diState;
	logic [5:0] tripOutputN;
	logic alarmSignalOutput, serviceStatusOutput;
	logic [31:0] seed = 32'h7872e8cd;
	logic [31:0] rv;
	int errors = 0;
	int testsRun = 0;
	int n, o, s;
	relay_io_matrix #(.TICK_DIV(4)) dut (.clk(clk), .resetn(resetn), .req(req), .rdata(rdata),
		.irq(irq), .internalSig(internalSig), .logicBind(logicBind),
		.digitalInputN(digitalInputN), .diState(diState), .tripOutputN(tripOutputN),
		.alarmSignalOutput(alarmSignalOutput), .serviceStatusOutput(serviceStatusOutput));
	field_contacts field (.clk(clk), .activeReq(activeReq), .ncType(ncType), .acFed(acFed),
		.digitalInputN(digitalInputN));
	initial begin
		forever #2.5 clk = ~clk;
	end
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	// Coil bit in register order: trips, then alarm, then service
	function automatic logic coil(input int i);
		logic [7:0] c;
		c = {serviceStatusOutput, alarmSignalOutput, tripOutputN};
		return c[i];
	endfunction
	task automatic completeRun();
		$display("checks %0d errors %0d", testsRun, errors);
		if (errors == 0 && testsRun > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		testsRun++;
		if (seen !== exp) begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// Idle cycles; strobes drop first
	task automatic cyc(input int c);
		req <= '0;
		logicBind <= '0;
		repeat (c) @(posedge clk);
	endtask
	// Bus cycles end one edge after the strobe so strobes never merge
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk);
		req <= '0;
		@(posedge clk);
	endtask
	task automatic rdChk(input logic [11:0] a, input logic [31:0] exp);
		req <= '{addr: a, wdata: '0, wr: 1'b0, rd: 1'b1};
		@(posedge clk);
		req <= '0;
		#1 rv = rdata;
		@(posedge clk);
		check($sformatf("read %h", a), rv, exp);
	endtask
	// Bounded wait for input 0 to reach a level
	task automatic waitDi(input logic lvl, output int c);
		c = 0;
		while (diState[0] !== lvl && c < 60) begin
			@(posedge clk);
			c++;
		end
		if (c >= 60) begin
			errors++;
			completeRun();
		end
	endtask
	initial begin
		#400000;
		errors++;
		completeRun();
	end
	initial begin
		repeat (3) @(posedge clk);
		resetn <= 1'b1;
		cyc(2);
		check("coils", {serviceStatusOutput, alarmSignalOutput, tripOutputN}, 0);
		check("diState", diState, 0);
		rdChk(ADDR_CTRL, 0);
		rdChk(12'h034, 0);
		// Forced writes count only with the flag on
		wr(ADDR_OUT_FORCE, 32'hff);
		cyc(3);
		check("forceOff", coil(0), 0);
		wr(ADDR_CTRL, 32'h1);
		wr(ADDR_OUT_FORCE, 32'ha5);
		cyc(3);
		rdChk(ADDR_OUT_STATE, 32'ha5);
		wr(ADDR_CTRL, 32'h0);
		cyc(3);
		check("forceBack", coil(0), 0);
		// Random routes: plain, latched crosspoint, latched output
		for (int k = 0; k < 9; k++) begin
			o = rnd() % 8;
			s = rnd() % 8;
			wr(ADDR_XP_BASE + 12'(4 * o), (32'h1 << s) | (k % 3 == 1 ? 32'h10000 << s : 0));
			wr(ADDR_OUT_LATCH, k % 3 == 2 ? 32'h1 << o : 0);
			internalSig <= 8'(rnd()) | (8'h1 << s);
			cyc(3);
			check("follow", coil(o), 1);
			internalSig <= 8'(rnd()) & ~(8'h1 << s);
			cyc(3);
			check("hold", coil(o), k % 3 != 0);
			wr(ADDR_CTRL, 32'h2);
			wr(ADDR_XP_BASE + 12'(4 * o), 0);
			cyc(3);
			check("release", coil(o), 0);
		end
		internalSig <= 8'h20;
		cyc(3);
		check("unbound", coil(3), 0);
		logicBind <= '{valid: 1'b1, src: 4'h5, out: 4'h3};
		@(posedge clk);
		cyc(3);
		check("bound", coil(3), 1);
		wr(ADDR_IRQ_ENABLE, 32'hffffff);
		wr(ADDR_DI_ON_EN, 32'hff);
		wr(ADDR_DI_OFF_EN, 32'hff);
		wr(ADDR_DI_ALM_EN, 32'hff);
		wr(ADDR_DI_DELAY_BASE, 32'd10);
		wr(ADDR_XP_BASE, 32'h100);
		// A latched output left by the random routes would hide the input following
		wr(ADDR_OUT_LATCH, 0);
		// Input 0 open then closed type; closed type starts at the counter top
		for (int i = 0; i < 2; i++) begin
			wr(ADDR_DI_POL, 32'(i));
			wr(ADDR_DI_COUNT_BASE, i ? 32'hffff : 0);
			ncType <= 8'(i);
			cyc(60);
			wr(ADDR_IRQ_CLEAR, 32'hffffff);
			cyc(3);
			check("irqClear", irq, 0);
			activeReq <= 8'h1;
			waitDi(i == 0, n);
			check("onDelay", n >= 37 && n <= 46, 1);
			cyc(4);
			check("irqOn", irq, 1);
			rdChk(ADDR_IRQ_STATUS, 32'h10001);
			rdChk(ADDR_DI_COUNT_BASE, i ? 0 : 1);
			check("diSource", coil(0), i == 0);
			wr(ADDR_IRQ_CLEAR, 32'hffffff);
			activeReq <= 8'h0;
			waitDi(i != 0, n);
			check("offDelay", n >= 37 && n <= 46, 1);
			cyc(4);
			rdChk(ADDR_IRQ_STATUS, 32'h100);
			rdChk(ADDR_DI_COUNT_BASE, i ? 0 : 1);
		end
		wr(ADDR_IRQ_ENABLE, 0);
		cyc(3);
		check("irqMask", irq, 0);
		// Ac-fed input 1 must ride over its supply gaps
		wr(ADDR_DI_AC, 32'h2);
		acFed <= 8'h2;
		activeReq <= 8'h2;
		cyc(20);
		for (int j = 0; j < 12; j++) begin
			check("acHold", diState[1], 1);
			cyc(1);
		end
		completeRun();
	end
endmodule
